// ===== include/trig_pkg.sv
package trig_pkg;
	// ==========================================================
	// Register map (word offsets as byte addresses)
	localparam logic [7:0] sync_param_addr = 8'h00;	// Sync-parameter word
	localparam logic [7:0] filter_ctrl_addr = 8'h04;	// Filter enable and characteristic
	localparam logic [7:0] mode_status_addr = 8'h08;	// Active mode, read only
	localparam logic [7:0] irq_status_addr = 8'h0C;	// Sticky events, read only
	localparam logic [7:0] irq_clear_addr = 8'h10;	// Write one to clear
	localparam logic [7:0] irq_enable_addr = 8'h14;	// Interrupt enables
	localparam logic [7:0] cycle_time_addr = 8'h18;	// Fieldbus cycle time in us
	localparam logic [7:0] shift_addr = 8'h1C;	// Sync shift in clocks, read only
	// ==========================================================
	// Field layout and reset values
	localparam int sync_mode_lsb = 0;
	localparam int fast_bit = 15;
	localparam logic [15:0] sync_param_reset = 16'h0000;
	localparam logic [1:0] sync_free = 2'h0;
	localparam logic [1:0] sync_frame = 2'h1;
	localparam logic [1:0] sync_dc = 2'h3;
	localparam int filter_en_bit = 0;
	localparam int filter_char_lsb = 4;	// 0: FIR 50 Hz, 1: FIR 60 Hz, 2: IIR
	localparam logic [1:0] char_fir50 = 2'h0;
	localparam logic [1:0] char_fir60 = 2'h1;
	localparam logic [1:0] char_iir = 2'h2;
	// Event bits
	localparam int ev_sample = 0;
	localparam int ev_reject = 1;
	localparam int ev_short_cycle = 2;
	localparam int ev_settling = 3;
	localparam int ev_duplicate = 4;
	localparam int ev_width = 5;
	// ==========================================================
	// Timing
	localparam int clk_mhz = 100;
	localparam int fir50_us = 625;
	localparam int fir60_us = 520;
	localparam int iir_us = 1000;
	localparam int fir50_cycles = fir50_us * clk_mhz;
	localparam int fir60_cycles = fir60_us * clk_mhz;
	localparam int iir_cycles = iir_us * clk_mhz;
	localparam int frame_min_12_us = 80;
	localparam int frame_min_4_us = 120;
	localparam int dc_min_1_us = 100;
	localparam int dc_min_2_us = 125;
	localparam int dc_min_4_us = 150;
	localparam int settle_samples = 4;	// Samples flagged unsettled after changeover
	localparam int conv_lead_us = 20;	// Conversion lead before the frame
	localparam int conv_lead_cycles = conv_lead_us * clk_mhz;
	// ==========================================================
	// Modes
	typedef enum logic [1:0] {
		mode_free = 2'b00,
		mode_frame = 2'b01,
		mode_dc = 2'b11
	} mode_type;
endpackage : trig_pkg

// ===== hdl/pulse_timer.sv
`timescale 1ns/1ps
// Programmable period tick: one pulse every period clocks, restarted on demand
module pulse_timer
	import trig_pkg::*;
#(
	parameter int width = 24
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             run,
	input  wire logic [width-1:0] period,
	output logic                  tick
);
	logic [width-1:0] count;	// Down counter

	// ==========================================================
	// Counter: reloads on expiry, cleared to zero while idle
	always_ff @(posedge clk) begin
		if (sys_rst || !run) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (count == '0) begin
			count <= period - width'(1);
			tick  <= 1'b1;
		end else begin
			count <= count - width'(1);
			tick  <= 1'b0;
		end
	end
endmodule : pulse_timer

// ===== hdl/edge_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser followed by a rising-edge pulse
module edge_sync (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic pin,
	output logic      rise
);
	logic meta;	// First stage, read only by stage two
	logic stable;	// Second stage
	logic last;	// Previous stable level

	// ==========================================================
	// Synchroniser and edge detect
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			last   <= 1'b0;
			rise   <= 1'b0;
		end else begin
			meta   <= pin;
			stable <= meta;
			last   <= stable;
			rise   <= stable & ~last;
		end
	end
endmodule : edge_sync

// ===== hdl/sample_trigger_mode_control.sv
`timescale 1ns/1ps
// Summary of operation
// - Three triggers: timer, frame, distributed-clock sync
// - Filter toggle switches modes, stays operational
// - Changeover flags unsettled samples until steady
// - Distributed clock only with filter off
// - Bit 15 fast option, not in sync mode
// - Free-run period 625us, 520us or 1ms
// - Frame mode samples every process-data frame
// - Sync mode samples on sync interrupt
// - Input-based sync shifted before the frame
// - Filter off by default, channel one setting
module sample_trigger_mode_control
	import trig_pkg::*;
#(
	parameter int channels = 2,	// 1, 2 or 4 channels
	parameter int fir50_count = fir50_cycles,	// Free-run period, FIR 50 Hz
	parameter int fir60_count = fir60_cycles,	// Free-run period, FIR 60 Hz
	parameter int iir_count = iir_cycles,	// Free-run period, IIR
	parameter int lead_count = conv_lead_cycles	// Conversion lead for shifting
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        frame_pin,
	input  wire logic        sync_pin,
	output logic             sample_strobe,
	output logic             settling,
	output logic [1:0]       active_mode,
	output logic             irq
);
	// ==========================================================
	// Declarations
	logic [15:0]          sync_param;	// Sync-parameter word
	logic                 filter_en;	// Filter enable
	logic [1:0]           filter_char;	// Shared characteristic
	logic [15:0]          cycle_us;	// Configured fieldbus cycle
	logic [ev_width-1:0]  ev_status;	// Sticky events
	logic [ev_width-1:0]  ev_enable;	// Interrupt enables
	logic [ev_width-1:0]  ev_set;	// Events this cycle
	logic [ev_width-1:0]  ev_clr;	// Clear strobe from bus
	logic                 frame_rise;	// Synchronised frame event
	logic                 sync_rise;	// Synchronised sync interrupt
	logic                 timer_tick;	// Free-run tick
	logic [23:0]          free_period;	// Selected free-run period
	logic                 wr;	// Bus write this cycle
	logic                 rd_ack;	// Access accepted
	logic                 reject;	// Illegal write refused
	logic [2:0]           settle_cnt;	// Samples still unsettled
	logic [1:0]           prev_mode;	// Mode last cycle
	logic                 prev_filter;	// Filter last cycle
	logic [31:0]          frame_gap;	// Clocks since last frame
	logic [31:0]          frame_period;	// Measured frame period
	logic [31:0]          shift_cycles;	// Sync-to-ready shift
	logic [31:0]          shift_cnt;	// Counts shifted sync delay
	logic                 shift_run;	// Shift delay in progress
	logic                 sampled_frame;	// Sample taken in current frame
	logic                 next_sample;	// Trigger selection

	// ==========================================================
	// Functions
	// Minimum cycle in us for the given mode and channel count
	function automatic logic [15:0] min_cycle(input logic [1:0] m);
		logic [15:0] v;
		v = 16'h0000;
		if (m == sync_frame) begin
			v = (channels >= 4) ? 16'(frame_min_4_us) : 16'(frame_min_12_us);
		end else if (m == sync_dc) begin
			v = (channels >= 4) ? 16'(dc_min_4_us) :
			    (channels == 2) ? 16'(dc_min_2_us) : 16'(dc_min_1_us);
		end
		return v;
	endfunction : min_cycle

	// Mode derived from the mode field, with the filter forcing free run
	function automatic logic [1:0] decode_mode(input logic [15:0] p, input logic f);
		logic [1:0] m;
		m = p[sync_mode_lsb +: 2];
		if (f) begin
			m = sync_free;
		end else if (m == sync_free) begin
			m = sync_frame;	// Filter off without sync selects frame mode
		end
		return m;
	endfunction : decode_mode

	// ==========================================================
	// Edge inputs, synchronised before use
	edge_sync frame_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     (frame_pin),
		.rise    (frame_rise)
	);
	edge_sync dc_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     (sync_pin),
		.rise    (sync_rise)
	);

	// ==========================================================
	// Free-run timer, period set by filter characteristic
	always_comb begin
		unique case (filter_char)
			char_fir60: free_period = 24'(fir60_count);
			char_iir:   free_period = 24'(iir_count);
			default:    free_period = 24'(fir50_count);
		endcase
	end

	pulse_timer #(.width(24)) free_timer (
		.clk     (clk),
		.sys_rst (sys_rst),
		.run     (active_mode == sync_free),
		.period  (free_period),
		.tick    (timer_tick)
	);

	// ==========================================================
	// Wishbone slave: single-cycle ack, one wait state before it
	assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign rd_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// Write refused when it would combine filter and sync mode
	always_comb begin
		reject = 1'b0;
		if (wr && wb_adr_i == filter_ctrl_addr && wb_sel_i[0]) begin
			reject = wb_dat_i[filter_en_bit] && sync_param[1:0] == sync_dc;
		end else if (wr && wb_adr_i == sync_param_addr && wb_sel_i[0]) begin
			reject = wb_dat_i[1:0] == sync_dc && filter_en;
		end
	end

	// Acknowledge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= rd_ack;
		end
	end

	// Read data, unmapped addresses return zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd_ack && !wb_we_i) begin
			unique case (wb_adr_i)
				sync_param_addr:  wb_dat_o <= {16'h0000, sync_param};
				filter_ctrl_addr: wb_dat_o <= {26'h0, filter_char, 3'h0, filter_en};
				mode_status_addr: wb_dat_o <= {27'h0, settling, 2'h0, active_mode};
				irq_status_addr:  wb_dat_o <= {27'h0, ev_status};
				irq_enable_addr:  wb_dat_o <= {27'h0, ev_enable};
				cycle_time_addr:  wb_dat_o <= {16'h0000, cycle_us};
				shift_addr:       wb_dat_o <= shift_cycles;
				default:          wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Sync-parameter word; the fast option is cleared in sync mode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync_param <= sync_param_reset;
		end else if (wr && wb_adr_i == sync_param_addr && !reject) begin
			if (wb_sel_i[0]) begin
				sync_param[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				sync_param[15:8] <= wb_dat_i[15:8];
			end
			if ((wb_sel_i[0] ? wb_dat_i[1:0] : sync_param[1:0]) == sync_dc) begin
				sync_param[fast_bit] <= 1'b0;
			end
		end
	end

	// Filter control; only this block's copy is held for all channels
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			filter_en   <= 1'b0;
			filter_char <= char_fir50;
		end else if (wr && wb_adr_i == filter_ctrl_addr && wb_sel_i[0] && !reject) begin
			filter_en   <= wb_dat_i[filter_en_bit];
			filter_char <= wb_dat_i[filter_char_lsb +: 2];
		end
	end

	// Cycle time and interrupt enables
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cycle_us  <= 16'h0000;
			ev_enable <= '0;
		end else if (wr) begin
			if (wb_adr_i == cycle_time_addr && wb_sel_i[0]) begin
				cycle_us[7:0] <= wb_dat_i[7:0];
			end
			if (wb_adr_i == cycle_time_addr && wb_sel_i[1]) begin
				cycle_us[15:8] <= wb_dat_i[15:8];
			end
			if (wb_adr_i == irq_enable_addr && wb_sel_i[0]) begin
				ev_enable <= wb_dat_i[ev_width-1:0];
			end
		end
	end

	// ==========================================================
	// Active mode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			active_mode <= sync_free;
			prev_mode   <= sync_free;
			prev_filter <= 1'b0;
		end else begin
			active_mode <= decode_mode(sync_param, filter_en);
			prev_mode   <= active_mode;
			prev_filter <= filter_en;
		end
	end

	// ==========================================================
	// Frame period measurement and input-based shift
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frame_gap    <= 32'h0000_0000;
			frame_period <= 32'h0000_0000;
		end else if (frame_rise) begin
			frame_gap    <= 32'h0000_0001;
			frame_period <= frame_gap;
		end else if (frame_gap != 32'hFFFF_FFFF) begin
			frame_gap <= frame_gap + 32'h0000_0001;
		end
	end

	// Sync delayed so conversion ends a lead time before the next frame
	// A frame period no longer than the lead gives no shift: the sample then follows the interrupt at once
	assign shift_cycles = (frame_period > 32'(lead_count)) ?
	                      frame_period - 32'(lead_count) : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (sys_rst || active_mode != sync_dc) begin
			shift_run <= 1'b0;
			shift_cnt <= 32'h0000_0000;
		end else if (sync_rise) begin
			shift_run <= 1'b1;
			shift_cnt <= shift_cycles;
		end else if (shift_run && shift_cnt != 32'h0000_0000) begin
			shift_cnt <= shift_cnt - 32'h0000_0001;
		end else begin
			shift_run <= 1'b0;
		end
	end

	// ==========================================================
	// Trigger selection
	always_comb begin
		unique case (active_mode)
			sync_frame: next_sample = frame_rise;
			sync_dc:    next_sample = shift_run && shift_cnt == 32'h0000_0000;
			default:    next_sample = timer_tick;
		endcase
	end

	// Sample strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sample_strobe <= 1'b0;
		end else begin
			sample_strobe <= next_sample;
		end
	end

	// One sample per frame; a second one in the same frame is flagged a duplicate in sync mode only
	always_ff @(posedge clk) begin
		if (sys_rst || frame_rise) begin
			sampled_frame <= 1'b0;
		end else if (next_sample) begin
			sampled_frame <= 1'b1;
		end
	end

	// ==========================================================
	// Settling after changeover: output may step until filter is steady
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			settle_cnt <= 3'h0;
		end else if (active_mode != prev_mode || filter_en != prev_filter) begin
			settle_cnt <= 3'(settle_samples);
		end else if (next_sample && settle_cnt != 3'h0) begin
			settle_cnt <= settle_cnt - 3'h1;
		end
	end
	assign settling = settle_cnt != 3'h0;

	// ==========================================================
	// Interrupts: set wins over clear
	always_comb begin
		ev_set = '0;
		ev_set[ev_sample]      = next_sample;
		ev_set[ev_reject]      = reject;
		ev_set[ev_short_cycle] = wr && wb_adr_i == cycle_time_addr && active_mode != sync_free &&
		                         wb_dat_i[15:0] < min_cycle(active_mode);
		ev_set[ev_settling]    = active_mode != prev_mode;
		ev_set[ev_duplicate]   = next_sample && sampled_frame && active_mode == sync_dc;
		ev_clr = (wr && wb_adr_i == irq_clear_addr && wb_sel_i[0]) ? wb_dat_i[ev_width-1:0] : '0;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ev_status <= '0;
		end else begin
			ev_status <= (ev_status & ~ev_clr) | ev_set;
		end
	end

	assign irq = |(ev_status & ev_enable);

	// ==========================================================
	// Checks
	chk_dc_no_filter: assert property (@(posedge clk) disable iff (sys_rst)
		active_mode == sync_dc |-> !filter_en && !$past(filter_en))
		else $error("sync mode active with filter on");
	chk_filter_free: assert property (@(posedge clk) disable iff (sys_rst)
		filter_en |=> active_mode == sync_free)
		else $error("filter on without free run");
	chk_frame_sample: assert property (@(posedge clk) disable iff (sys_rst)
		active_mode == sync_frame && frame_rise && $past(active_mode) == sync_frame |=> sample_strobe)
		else $error("frame without sample");
	chk_fast_off_dc: assert property (@(posedge clk) disable iff (sys_rst)
		sync_param[1:0] == sync_dc |-> !sync_param[fast_bit])
		else $error("fast option in sync mode");
	chk_settle_start: assert property (@(posedge clk) disable iff (sys_rst)
		active_mode != prev_mode |=> settling)
		else $error("changeover not flagged");
	chk_reject_keep: assert property (@(posedge clk) disable iff (sys_rst)
		reject && wb_adr_i == filter_ctrl_addr |=> !filter_en)
		else $error("filter enabled in sync mode");
	chk_dc_sample: assert property (@(posedge clk) disable iff (sys_rst)
		sample_strobe && active_mode == sync_dc && $past(active_mode) == sync_dc |-> $past(shift_run))
		else $error("sync sample without interrupt");
	chk_free_only_timer: assert property (@(posedge clk) disable iff (sys_rst)
		active_mode == sync_free && $past(active_mode) == sync_free && !$past(timer_tick) |-> !sample_strobe)
		else $error("free-run sample off timer");
endmodule : sample_trigger_mode_control

// ===== bench/fieldbus_master_model.sv
`timescale 1ns/1ps
// ==========================================================
// Far side: sends frame and sync events at a fixed period
module fieldbus_master_model (
	input  wire logic        clk,
	input  wire logic        run_frame,	// Send frame events
	input  wire logic        run_sync,	// Send sync events
	input  wire logic [15:0] period,	// Cycle length in clocks
	output logic             frame_pin,
	output logic             sync_pin
);
	logic [15:0] pos;	// Position in the cycle
	initial begin
		pos = 16'h0000;
		frame_pin = 1'b0;
		sync_pin = 1'b0;
	end
	// A steady cycle with no jitter, so no duplicate can arise; pins rest low between events
	// Pulses last four clocks so the two-stage synchroniser sees them
	always @(posedge clk) begin
		pos <= (pos >= period - 16'h0001) ? 16'h0000 : pos + 16'h0001;
		frame_pin <= run_frame && (pos < 16'h0004);
		sync_pin <= run_sync && (pos >= 16'h0008) && (pos < 16'h000C);
	end
endmodule : fieldbus_master_model

// ===== bench/test_sample_trigger_mode_control.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the trigger mode control
module test_sample_trigger_mode_control
	import trig_pkg::*;
;
	typedef struct packed {
		logic [15:0] sync_wr;	// Sync word written
		logic [7:0]  filt_wr;	// Filter word written
		logic [1:0]  exp_mode;	// Mode expected
		logic [15:0] exp_sync;	// Sync word read back
	} row_type;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic [31:0] wb_dat_o, rd;
	logic        wb_ack_o, frame_pin, sync_pin, sample_strobe, settling, irq;
	logic [1:0]  active_mode;
	logic        run_frame = 1'b0, run_sync = 1'b0;
	logic [15:0] period = 16'h0190;	// 400 clocks a cycle
	int          err_total = 0, n_tests = 0;
	int          cyc = 0, last = 0, gap = 0, strobes = 0, s0;
	row_type     rows [8];
	logic [15:0] gaps [3] = '{16'h0032, 16'h0028, 16'h003C};	// 50, 40, 60 clocks
	// ==========================================================
	// Clock and strobe monitor: count strobes and their spacing
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (sample_strobe === 1'b1) begin
			strobes <= strobes + 1;
			gap <= cyc - last;
			last <= cyc;
		end
	end
	sample_trigger_mode_control #(.channels(2), .fir50_count(50), .fir60_count(40), .iir_count(60),
		.lead_count(5)) dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .frame_pin(frame_pin), .sync_pin(sync_pin), .sample_strobe(sample_strobe),
		.settling(settling), .active_mode(active_mode), .irq(irq));
	fieldbus_master_model partner (.clk(clk), .run_frame(run_frame), .run_sync(run_sync),
		.period(period), .frame_pin(frame_pin), .sync_pin(sync_pin));
	// ==========================================================
	// One classic cycle; held until ack, then one idle cycle
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= 4'hF;
		wb_dat <= wd;
		// No cycle count is assumed; the ack ends this wait, or else the watchdog
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clk);
	endtask : wb_xfer
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic results();
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	// Watchdog against a hang: the full run takes about 75400 clocks
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		results();
	end
	// ==========================================================
	// Main sequence
	initial begin
		rows[0] = '{16'h0000, 8'h00, 2'h1, 16'h0000};
		rows[1] = '{16'h8001, 8'h00, 2'h1, 16'h8001};
		rows[2] = '{16'h0003, 8'h00, 2'h3, 16'h0003};
		rows[3] = '{16'h8003, 8'h00, 2'h3, 16'h0003};	// Fast option dropped in sync mode
		rows[4] = '{16'h0003, 8'h01, 2'h3, 16'h0003};	// Filter refused in sync mode
		rows[5] = '{16'h0000, 8'h01, 2'h0, 16'h0000};
		rows[6] = '{16'h8000, 8'h11, 2'h0, 16'h8000};
		rows[7] = '{16'h0003, 8'h11, 2'h0, 16'h8000};	// Sync mode refused, filter on
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		check("irq after reset", 32'h0, {31'h0, irq});
		wb_xfer(1'b0, sync_param_addr, 32'h0);
		check("sync reset", 32'h0, rd);
		wb_xfer(1'b0, filter_ctrl_addr, 32'h0);
		check("filter reset", 32'h0, rd);
		check("mode reset", 32'h1, {30'h0, active_mode});
		wb_xfer(1'b0, 8'h20, 32'h0);
		check("unmapped read", 32'h0, rd);
		for (int i = 0; i < 8; i++) begin
			wb_xfer(1'b1, sync_param_addr, {16'h0, rows[i].sync_wr});
			wb_xfer(1'b1, filter_ctrl_addr, {24'h0, rows[i].filt_wr});
			repeat (3) @(posedge clk);
			check("mode", {30'h0, rows[i].exp_mode}, {30'h0, active_mode});
			wb_xfer(1'b0, sync_param_addr, 32'h0);
			check("sync word", {16'h0, rows[i].exp_sync}, rd[31:0]);
		end
		// Interrupt: refusal event raised, masked, cleared
		wb_xfer(1'b1, irq_clear_addr, 32'h1F);
		wb_xfer(1'b1, irq_enable_addr, 32'h02);
		wb_xfer(1'b1, sync_param_addr, 32'h3);
		check("irq on reject", 32'h1, {31'h0, irq});
		wb_xfer(1'b1, irq_enable_addr, 32'h0);
		check("irq masked", 32'h0, {31'h0, irq});
		wb_xfer(1'b1, irq_clear_addr, 32'h02);
		wb_xfer(1'b0, irq_status_addr, 32'h0);
		check("reject cleared", 32'h0, rd & 32'h2);
		// Free run periods for each characteristic, settling after changeover
		for (int c = 0; c < 3; c++) begin
			if (c == 0) wb_xfer(1'b1, filter_ctrl_addr, 32'h0);	// Filter off first, so turning it on is a changeover
			wb_xfer(1'b1, filter_ctrl_addr, {26'h0, c[1:0], 4'h1});
			if (c == 0) check("settling", 32'h1, {31'h0, settling});
			repeat (400) @(posedge clk);
			check("free period", {16'h0, gaps[c]}, gap);
		end
		check("settled", 32'h0, {31'h0, settling});
		// Frame mode: one strobe per frame, short cycle flagged
		wb_xfer(1'b1, filter_ctrl_addr, 32'h0);
		wb_xfer(1'b1, sync_param_addr, 32'h1);
		wb_xfer(1'b1, irq_clear_addr, 32'h1F);
		wb_xfer(1'b1, cycle_time_addr, 32'd50);
		wb_xfer(1'b0, irq_status_addr, 32'h0);
		check("short cycle", 32'h4, rd & 32'h4);
		wb_xfer(1'b1, cycle_time_addr, 32'd80);
		wb_xfer(1'b1, irq_clear_addr, 32'h1F);
		wb_xfer(1'b0, irq_status_addr, 32'h0);
		check("cycle at limit", 32'h0, rd & 32'h4);
		// Partner runs the shortest legal frame cycle, 8000 clocks
		period <= 16'(frame_min_12_us * clk_mhz);
		run_frame <= 1'b1;
		repeat (8000) @(posedge clk);
		s0 = strobes;
		repeat (16000) @(posedge clk);
		check("frame strobes", 32'd2, strobes - s0);
		// Sync mode: one strobe per cycle, shift ahead of the frame
		period <= 16'(dc_min_2_us * clk_mhz);
		wb_xfer(1'b1, cycle_time_addr, 32'd125);
		wb_xfer(1'b1, sync_param_addr, 32'h3);
		run_sync <= 1'b1;
		repeat (25000) @(posedge clk);
		s0 = strobes;
		repeat (25000) @(posedge clk);
		check("sync strobes", 32'd2, strobes - s0);
		wb_xfer(1'b0, shift_addr, 32'h0);
		check("sync shift", 32'(dc_min_2_us * clk_mhz - 5), rd);
		results();
	end
endmodule : test_sample_trigger_mode_control
